// File: logic/fcb_alu_unit.sv
`timescale 1ns/1ps
`default_nettype none
module fcb_alu_unit
(
	input wire fcb_pkg::fcb_op_t opSel,
	input wire logic destSel,
	input wire logic [7:0] fileData,
	input wire logic [7:0] workData,
	input wire logic [7:0] literalByte,
	output logic [7:0] result,
	output logic toWork,
	output logic toFile,
	output logic zeroUpdate,
	output logic zeroValue,
	output logic redirect,
	output logic isJump
);

	always_comb
	begin
		result = fcb_pkg::ZERO_BYTE;
		toWork = 1'b0;
		toFile = 1'b0;
		zeroUpdate = 1'b0;
		redirect = 1'b0;
		isJump = 1'b0;
		unique case (opSel)
			fcb_pkg::CLEAR_FILE_REG_OP:
			begin
				toFile = 1'b1;
				zeroUpdate = 1'b1;
			end
			fcb_pkg::DECREMENT_FILE_OP:
			begin
				result = fileData - fcb_pkg::ONE_BYTE;
				toWork = (destSel == fcb_pkg::DEST_WORK);
				toFile = (destSel == fcb_pkg::DEST_FILE);
				zeroUpdate = 1'b1;
			end
			fcb_pkg::CLEAR_WORK_REG_OP:
			begin
				toWork = 1'b1;
				zeroUpdate = 1'b1;
			end
			fcb_pkg::DECREMENT_SKIP_ZERO_OP:
			begin
				result = fileData - fcb_pkg::ONE_BYTE;
				toWork = (destSel == fcb_pkg::DEST_WORK);
				toFile = (destSel == fcb_pkg::DEST_FILE);
				redirect = (result == fcb_pkg::ZERO_BYTE);
			end
			fcb_pkg::INCREMENT_SKIP_ZERO_OP:
			begin
				result = fileData + fcb_pkg::ONE_BYTE;
				toWork = (destSel == fcb_pkg::DEST_WORK);
				toFile = (destSel == fcb_pkg::DEST_FILE);
				redirect = (result == fcb_pkg::ZERO_BYTE);
			end
			fcb_pkg::JUMP_OP:
			begin
				isJump = 1'b1;
				redirect = 1'b1;
			end
			fcb_pkg::OR_LITERAL_INTO_WORK_OP:
			begin
				result = workData | literalByte;
				toWork = 1'b1;
				zeroUpdate = 1'b1;
			end
			fcb_pkg::NO_OPERATION:
			begin
				result = fcb_pkg::ZERO_BYTE;
			end
		endcase
	end

	// Clearing results are zero, so the same test sets the flag for them.
	assign zeroValue = (result == fcb_pkg::ZERO_BYTE);

endmodule : fcb_alu_unit
`default_nettype wire

// File: logic/fcb_exec_unit.sv
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Clear file register writes zero, sets zero.
// - Decrement file, route by destination, zero flag.
// - Clear working register, set zero flag.
// - Decrement, skip next on zero, status untouched.
// - Increment, skip next on zero, status untouched.
// - Jump loads 11-bit literal into low bits.
// - Jump fills top bits from page latch (narrow build: top two bits zero).
// - Jump is unconditional, two cycles, discards next.
// - OR literal into working register, zero flag.
module fcb_exec_unit
#(
	parameter bit PAGE_NARROW = 1'b0
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic opValid,
	input wire fcb_pkg::fcb_op_t opSel,
	input wire logic [6:0] fileAddr,
	input wire logic destSel,
	input wire logic [10:0] literal,
	input wire logic [7:0] fileRdData,
	input wire logic [7:0] workIn,
	input wire logic [7:0] pageLatchIn,
	output logic fileWrEn,
	output logic [6:0] fileWrAddr,
	output logic [7:0] fileWrData,
	output logic workWrEn,
	output logic [7:0] workWrData,
	output logic zeroWrEn,
	output logic zeroVal,
	output logic pcLoadEn,
	output logic [14:0] pcLoadAddr,
	output logic nopSlot
);

	////////////////////////////////////////////////////////////////////////
	// Operation datapath.

	logic takeOp;
	logic [7:0] aluResult;
	logic aluToWork;
	logic aluToFile;
	logic aluZeroUpd;
	logic aluZeroVal;
	logic aluRedirect;
	logic aluJump;
	logic [3:0] pageBits;

	// The instruction in a replaced slot is dropped entirely.
	assign takeOp = opValid && !nopSlot;

	fcb_alu_unit u_alu
	(
		.opSel(opSel),
		.destSel(destSel),
		.fileData(fileRdData),
		.workData(workIn),
		.literalByte(literal[7:0]),
		.result(aluResult),
		.toWork(aluToWork),
		.toFile(aluToFile),
		.zeroUpdate(aluZeroUpd),
		.zeroValue(aluZeroVal),
		.redirect(aluRedirect),
		.isJump(aluJump)
	);

	fcb_flow_ctrl u_flow
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.takeOp(takeOp),
		.redirect(aluRedirect),
		.nopSlot(nopSlot)
	);

	// Which latch bits reach the program counter is a build-time choice.
	generate
		if (PAGE_NARROW)
		begin : g_page_narrow
			assign pageBits = {2'b00,
				pageLatchIn[fcb_pkg::PAGE_NARROW_HI_BIT:fcb_pkg::PAGE_LO_BIT]};
		end
		else
		begin : g_page_wide
			assign pageBits =
				pageLatchIn[fcb_pkg::PAGE_HI_BIT:fcb_pkg::PAGE_LO_BIT];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Result registers.

	logic fileWrEn_reg;
	logic fileWrEn_next;
	logic [6:0] fileWrAddr_reg;
	logic [6:0] fileWrAddr_next;
	logic [7:0] fileWrData_reg;
	logic [7:0] fileWrData_next;
	logic workWrEn_reg;
	logic workWrEn_next;
	logic [7:0] workWrData_reg;
	logic [7:0] workWrData_next;
	logic zeroWrEn_reg;
	logic zeroWrEn_next;
	logic zeroVal_reg;
	logic zeroVal_next;
	logic pcLoadEn_reg;
	logic pcLoadEn_next;
	logic [14:0] pcLoadAddr_reg;
	logic [14:0] pcLoadAddr_next;

	always_comb
	begin
		fileWrEn_next = takeOp && aluToFile;
		fileWrAddr_next = fileAddr;
		fileWrData_next = aluResult;
		workWrEn_next = takeOp && aluToWork;
		workWrData_next = aluResult;
		zeroWrEn_next = takeOp && aluZeroUpd;
		zeroVal_next = aluZeroVal;
		pcLoadEn_next = takeOp && aluJump;
		pcLoadAddr_next = {pageBits, literal};
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fileWrEn_reg <= 1'b0;
			fileWrAddr_reg <= fcb_pkg::RESET_ADDR;
			fileWrData_reg <= fcb_pkg::ZERO_BYTE;
			workWrEn_reg <= 1'b0;
			workWrData_reg <= fcb_pkg::ZERO_BYTE;
			zeroWrEn_reg <= 1'b0;
			zeroVal_reg <= 1'b0;
			pcLoadEn_reg <= 1'b0;
			pcLoadAddr_reg <= fcb_pkg::RESET_PC;
		end
		else
		begin
			fileWrEn_reg <= fileWrEn_next;
			fileWrAddr_reg <= fileWrAddr_next;
			fileWrData_reg <= fileWrData_next;
			workWrEn_reg <= workWrEn_next;
			workWrData_reg <= workWrData_next;
			zeroWrEn_reg <= zeroWrEn_next;
			zeroVal_reg <= zeroVal_next;
			pcLoadEn_reg <= pcLoadEn_next;
			pcLoadAddr_reg <= pcLoadAddr_next;
		end
	end

	assign fileWrEn = fileWrEn_reg;
	assign fileWrAddr = fileWrAddr_reg;
	assign fileWrData = fileWrData_reg;
	assign workWrEn = workWrEn_reg;
	assign workWrData = workWrData_reg;
	assign zeroWrEn = zeroWrEn_reg;
	assign zeroVal = zeroVal_reg;
	assign pcLoadEn = pcLoadEn_reg;
	assign pcLoadAddr = pcLoadAddr_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	logic [3:0] expPage;
	assign expPage = PAGE_NARROW ? {2'b00, pageLatchIn[4:3]} :
		pageLatchIn[6:3];

	sequence s_one_nop;
		nopSlot ##1 !nopSlot;
	endsequence

	sequence s_no_status;
		!zeroWrEn;
	endsequence

	a_clear_file_zero: assert property (
		takeOp && opSel == fcb_pkg::CLEAR_FILE_REG_OP |=>
		fileWrEn && fileWrData == 8'h00 && fileWrAddr == $past(fileAddr)
		&& zeroWrEn && zeroVal && !workWrEn && !pcLoadEn)
		else $error("clear file register result wrong");

	a_decrement_route: assert property (
		takeOp && opSel == fcb_pkg::DECREMENT_FILE_OP |=>
		(workWrEn != fileWrEn) && (fileWrEn == $past(destSel))
		&& (workWrEn ? workWrData : fileWrData)
		== ($past(fileRdData) - 8'h01) && zeroWrEn)
		else $error("decrement result or routing wrong");

	a_clear_work: assert property (
		takeOp && opSel == fcb_pkg::CLEAR_WORK_REG_OP |=>
		workWrEn && workWrData == 8'h00 && zeroWrEn && zeroVal
		&& !fileWrEn)
		else $error("clear working register result wrong");

	a_dec_skip: assert property (
		takeOp && opSel == fcb_pkg::DECREMENT_SKIP_ZERO_OP
		&& fileRdData == 8'h01 |=> s_no_status ##0 s_one_nop)
		else $error("decrement zero did not skip once");

	a_dec_noskip: assert property (
		takeOp && opSel == fcb_pkg::DECREMENT_SKIP_ZERO_OP
		&& fileRdData != 8'h01 |=> !nopSlot && !zeroWrEn
		&& (workWrEn ? workWrData : fileWrData)
		== ($past(fileRdData) - 8'h01))
		else $error("decrement nonzero skipped or set status");

	a_nop_quiet: assert property (
		nopSlot |=> !fileWrEn && !workWrEn && !zeroWrEn && !pcLoadEn)
		else $error("discarded instruction had an effect");

	a_inc_skip: assert property (
		takeOp && opSel == fcb_pkg::INCREMENT_SKIP_ZERO_OP
		&& fileRdData == 8'hFF |=> s_no_status ##0 s_one_nop)
		else $error("increment zero did not skip once");

	a_jump_low: assert property (
		takeOp && opSel == fcb_pkg::JUMP_OP |=>
		pcLoadEn && pcLoadAddr[10:0] == $past(literal) && !zeroWrEn
		&& !workWrEn && !fileWrEn)
		else $error("jump low address wrong");

	a_jump_page: assert property (
		takeOp && opSel == fcb_pkg::JUMP_OP |=>
		pcLoadAddr[14:11] == $past(expPage))
		else $error("jump page bits wrong");

	a_jump_flush: assert property (
		takeOp && opSel == fcb_pkg::JUMP_OP |=> s_one_nop)
		else $error("jump did not discard exactly one slot");

	a_or_literal: assert property (
		takeOp && opSel == fcb_pkg::OR_LITERAL_INTO_WORK_OP |=>
		workWrEn && workWrData == ($past(workIn) | $past(literal[7:0]))
		&& zeroWrEn && !fileWrEn)
		else $error("or literal result wrong");

	a_zero_flag: assert property (
		zeroWrEn |->
		zeroVal == ((workWrEn ? workWrData : fileWrData) == 8'h00))
		else $error("zero flag disagrees with result");

	a_dec_skip_route: assert property (
		takeOp && opSel == fcb_pkg::DECREMENT_SKIP_ZERO_OP |=>
		(workWrEn != fileWrEn) && (fileWrEn == $past(destSel))
		&& (workWrEn ? workWrData : fileWrData)
		== ($past(fileRdData) - 8'h01) && !pcLoadEn)
		else $error("decrement skip result or routing wrong");

	a_inc_route: assert property (
		takeOp && opSel == fcb_pkg::INCREMENT_SKIP_ZERO_OP |=>
		(workWrEn != fileWrEn) && (fileWrEn == $past(destSel))
		&& (workWrEn ? workWrData : fileWrData)
		== ($past(fileRdData) + 8'h01) && !pcLoadEn)
		else $error("increment skip result or routing wrong");

	a_inc_noskip: assert property (
		takeOp && opSel == fcb_pkg::INCREMENT_SKIP_ZERO_OP
		&& fileRdData != 8'hFF |=> !nopSlot && !zeroWrEn)
		else $error("increment nonzero skipped or set status");

	a_dec_zero_value: assert property (
		takeOp && opSel == fcb_pkg::DECREMENT_FILE_OP |=>
		zeroVal == ($past(fileRdData) == 8'h01))
		else $error("decrement zero flag value wrong");

	a_or_zero_value: assert property (
		takeOp && opSel == fcb_pkg::OR_LITERAL_INTO_WORK_OP |=>
		zeroVal == (($past(workIn) | $past(literal[7:0])) == 8'h00))
		else $error("or literal zero flag value wrong");

	a_plain_no_skip: assert property (
		takeOp && (opSel == fcb_pkg::DECREMENT_FILE_OP
		|| opSel == fcb_pkg::OR_LITERAL_INTO_WORK_OP) |=>
		!nopSlot && !pcLoadEn)
		else $error("plain operation discarded the next slot");

	a_clear_no_skip: assert property (
		takeOp && (opSel == fcb_pkg::CLEAR_WORK_REG_OP
		|| opSel == fcb_pkg::CLEAR_FILE_REG_OP) |=> !nopSlot && !pcLoadEn)
		else $error("clear operation discarded the next slot");

	a_skip_single: assert property (
		nopSlot |=> !nopSlot)
		else $error("more than one slot discarded");

	a_noop_quiet: assert property (
		takeOp && opSel == fcb_pkg::NO_OPERATION |=>
		!fileWrEn && !workWrEn && !zeroWrEn && !pcLoadEn && !nopSlot)
		else $error("no operation had an effect");

	a_idle_quiet: assert property (
		!takeOp |=> !fileWrEn && !workWrEn && !zeroWrEn && !pcLoadEn)
		else $error("output pulsed without a taken instruction");

endmodule : fcb_exec_unit
`default_nettype wire

// File: logic/fcb_flow_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module fcb_flow_ctrl
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic takeOp,
	input wire logic redirect,
	output logic nopSlot
);

	fcb_pkg::fcb_state_t state_reg;
	fcb_pkg::fcb_state_t state_next;

	// A redirect turns the following slot into a no-operation.
	always_comb
	begin
		state_next = fcb_pkg::ST_RUN;
		unique case (state_reg)
			fcb_pkg::ST_RUN:
			begin
				if (takeOp && redirect)
				begin
					state_next = fcb_pkg::ST_NOP;
				end
			end
			fcb_pkg::ST_NOP:
			begin
				state_next = fcb_pkg::ST_RUN;
			end
			default:
			begin
				state_next = fcb_pkg::ST_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= fcb_pkg::ST_RUN;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign nopSlot = (state_reg == fcb_pkg::ST_NOP);

endmodule : fcb_flow_ctrl
`default_nettype wire

// File: shared/fcb_pkg.sv
`default_nettype none
package fcb_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths.
	localparam int FILE_ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int JUMP_LIT_W = 11;
	localparam int PC_W = 15;
	localparam int PAGE_W = 4;

	////////////////////////////////////////////////////////////////////////
	// Page latch field positions feeding the top program counter bits.
	localparam int PAGE_HI_BIT = 6;
	localparam int PAGE_LO_BIT = 3;
	localparam int PAGE_NARROW_HI_BIT = 4;

	////////////////////////////////////////////////////////////////////////
	// Constant values.
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ONE_BYTE = 8'h01;
	localparam logic [6:0] RESET_ADDR = 7'h00;
	localparam logic [14:0] RESET_PC = 15'h0000;
	localparam logic DEST_WORK = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Operation select from instruction decode.
	typedef enum logic [2:0]
	{
		CLEAR_FILE_REG_OP = 3'h0,
		DECREMENT_FILE_OP = 3'h1,
		CLEAR_WORK_REG_OP = 3'h2,
		DECREMENT_SKIP_ZERO_OP = 3'h3,
		INCREMENT_SKIP_ZERO_OP = 3'h4,
		JUMP_OP = 3'h5,
		OR_LITERAL_INTO_WORK_OP = 3'h6,
		NO_OPERATION = 3'h7
	} fcb_op_t;

	// Execution slot: a normal slot, or a slot replaced by a no-operation.
	typedef enum logic [1:0]
	{
		ST_RUN = 2'b01,
		ST_NOP = 2'b10
	} fcb_state_t;

endpackage : fcb_pkg
`default_nettype wire

// File: test/fcb_exec_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic opValid = 1'b0;
	fcb_pkg::fcb_op_t opSel = fcb_pkg::NO_OPERATION;
	logic [6:0] fileAddr = 7'h00;
	logic destSel = 1'b0;
	logic [10:0] literal = 11'h000;
	logic [7:0] fileRdData = 8'h00;
	logic [7:0] workIn = 8'h00;
	logic [7:0] pageLatchIn = 8'h00;
	logic fileWrEn, workWrEn, zeroWrEn, zeroVal, pcLoadEn, nopSlot;
	logic [6:0] fileWrAddr;
	logic [7:0] fileWrData, workWrData;
	logic [14:0] pcLoadAddr;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;

	fcb_exec_unit DUT (.mclk(mclk), .rst_n(rst_n), .opValid(opValid),
		.opSel(opSel), .fileAddr(fileAddr), .destSel(destSel),
		.literal(literal), .fileRdData(fileRdData), .workIn(workIn),
		.pageLatchIn(pageLatchIn), .fileWrEn(fileWrEn),
		.fileWrAddr(fileWrAddr), .fileWrData(fileWrData),
		.workWrEn(workWrEn), .workWrData(workWrData), .zeroWrEn(zeroWrEn),
		.zeroVal(zeroVal), .pcLoadEn(pcLoadEn), .pcLoadAddr(pcLoadAddr),
		.nopSlot(nopSlot));

	always #10 mclk = ~mclk;

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		if (fail_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic chk(input string n, input logic [14:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Presents one instruction in the cycle after the next edge.
	task automatic put(input fcb_pkg::fcb_op_t op, input logic [6:0] a,
		input logic d, input logic [10:0] k, input logic [7:0] fr, w, pg);
		@(posedge mclk);
		opValid <= 1'b1;
		opSel <= op;
		fileAddr <= a;
		destSel <= d;
		literal <= k;
		fileRdData <= fr;
		workIn <= w;
		pageLatchIn <= pg;
	endtask : put

	task automatic idle;
		@(posedge mclk);
		opValid <= 1'b0;
	endtask : idle

	// Flags are fileWrEn, workWrEn, zeroWrEn, pcLoadEn, nopSlot.
	task automatic look(input logic [4:0] f, input logic z,
		input logic [7:0] fd, wd);
		#1;
		chk("flags", 15'(f), 15'({fileWrEn, workWrEn, zeroWrEn, pcLoadEn,
			nopSlot}));
		if (f[4])
			chk("fileWrData", 15'(fd), 15'(fileWrData));
		if (f[3])
			chk("workWrData", 15'(wd), 15'(workWrData));
		if (f[2])
			chk("zeroVal", 15'(z), 15'(zeroVal));
	endtask : look

	////////////////////////////////////////////////////////////////////////
	task automatic t_clear_file;
		put(fcb_pkg::CLEAR_FILE_REG_OP, 7'h7F, 1'b0, 11'h000, 8'hA5, 8'h3C,
			8'h00);
		idle();
		look(5'h14, 1'b1, 8'h00, 8'h00);
		chk("fileWrAddr", 15'(7'h7F), 15'(fileWrAddr));
	endtask : t_clear_file

	task automatic t_decrement;
		put(fcb_pkg::DECREMENT_FILE_OP, 7'h12, 1'b0, 11'h000, 8'h01, 8'h00,
			8'h00);
		put(fcb_pkg::DECREMENT_FILE_OP, 7'h34, 1'b1, 11'h000, 8'h00, 8'h00,
			8'h00);
		look(5'h0C, 1'b1, 8'h00, 8'h00);
		idle();
		look(5'h14, 1'b0, 8'hFF, 8'h00);
		chk("fileWrAddr", 15'(7'h34), 15'(fileWrAddr));
	endtask : t_decrement

	task automatic t_clear_work;
		put(fcb_pkg::CLEAR_WORK_REG_OP, 7'h00, 1'b1, 11'h7FF, 8'h55, 8'h77,
			8'h00);
		idle();
		look(5'h0C, 1'b1, 8'h00, 8'h00);
	endtask : t_clear_work

	task automatic t_dec_skip;
		put(fcb_pkg::DECREMENT_SKIP_ZERO_OP, 7'h21, 1'b1, 11'h000, 8'h01,
			8'h00, 8'h00);
		put(fcb_pkg::CLEAR_FILE_REG_OP, 7'h05, 1'b1, 11'h000, 8'h00, 8'h00,
			8'h00);
		look(5'h11, 1'b0, 8'h00, 8'h00);
		idle();
		look(5'h00, 1'b0, 8'h00, 8'h00);
		put(fcb_pkg::DECREMENT_SKIP_ZERO_OP, 7'h21, 1'b0, 11'h000, 8'h05,
			8'h00, 8'h00);
		idle();
		look(5'h08, 1'b0, 8'h00, 8'h04);
	endtask : t_dec_skip

	task automatic t_inc_skip;
		put(fcb_pkg::INCREMENT_SKIP_ZERO_OP, 7'h40, 1'b0, 11'h000, 8'hFF,
			8'h00, 8'h00);
		put(fcb_pkg::CLEAR_WORK_REG_OP, 7'h00, 1'b0, 11'h000, 8'h00, 8'h00,
			8'h00);
		look(5'h09, 1'b0, 8'h00, 8'h00);
		idle();
		look(5'h00, 1'b0, 8'h00, 8'h00);
		put(fcb_pkg::INCREMENT_SKIP_ZERO_OP, 7'h40, 1'b1, 11'h000, 8'h7F,
			8'h00, 8'h00);
		idle();
		look(5'h10, 1'b0, 8'h80, 8'h00);
	endtask : t_inc_skip

	task automatic t_jump;
		put(fcb_pkg::JUMP_OP, 7'h00, 1'b0, 11'h5A5, 8'h00, 8'h00, 8'h78);
		put(fcb_pkg::OR_LITERAL_INTO_WORK_OP, 7'h00, 1'b0, 11'h0FF, 8'h00,
			8'h00, 8'h00);
		look(5'h03, 1'b0, 8'h00, 8'h00);
		chk("pcLoadAddr", 15'h7DA5, pcLoadAddr);
		idle();
		look(5'h00, 1'b0, 8'h00, 8'h00);
		put(fcb_pkg::JUMP_OP, 7'h00, 1'b0, 11'h7FF, 8'h00, 8'h00, 8'h87);
		idle();
		look(5'h03, 1'b0, 8'h00, 8'h00);
		chk("pcLoadAddr", 15'h07FF, pcLoadAddr);
	endtask : t_jump

	task automatic t_or_literal;
		put(fcb_pkg::OR_LITERAL_INTO_WORK_OP, 7'h00, 1'b1, 11'h7F0, 8'h00,
			8'h0F, 8'h00);
		put(fcb_pkg::OR_LITERAL_INTO_WORK_OP, 7'h00, 1'b1, 11'h700, 8'hFF,
			8'h00, 8'h00);
		look(5'h0C, 1'b0, 8'h00, 8'hFF);
		idle();
		look(5'h0C, 1'b1, 8'h00, 8'h00);
		put(fcb_pkg::NO_OPERATION, 7'h11, 1'b1, 11'h000, 8'h01, 8'h01, 8'h00);
		idle();
		look(5'h00, 1'b0, 8'h00, 8'h00);
	endtask : t_or_literal

	// Reset lands in the slot after a jump; the next op must still run.
	task automatic t_reset_mid;
		put(fcb_pkg::JUMP_OP, 7'h00, 1'b0, 11'h123, 8'h00, 8'h00, 8'h08);
		idle();
		rst_n <= 1'b0;
		#1;
		chk("reset flags mid", 15'h0000, 15'({fileWrEn, workWrEn,
			zeroWrEn, pcLoadEn, nopSlot}));
		chk("reset pcLoadAddr", 15'h0000, pcLoadAddr);
		@(posedge mclk);
		rst_n <= 1'b1;
		put(fcb_pkg::OR_LITERAL_INTO_WORK_OP, 7'h00, 1'b0, 11'h021, 8'h00,
			8'h40, 8'h00);
		idle();
		look(5'h0C, 1'b0, 8'h00, 8'h61);
	endtask : t_reset_mid

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		#1;
		chk("reset flags", 15'h0000, 15'({fileWrEn, workWrEn, zeroWrEn,
			pcLoadEn, nopSlot}));
		t_clear_file();
		t_decrement();
		t_clear_work();
		t_dec_skip();
		t_inc_skip();
		t_jump();
		t_or_literal();
		t_reset_mid();
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
